// file: hdl/pfcps_pkg.sv
package pfcps_pkg;
    // -------------------------------------------------------------
    // Clock and timing
    // -------------------------------------------------------------
    localparam int unsigned CLK_MHZ         = 250;
    localparam int unsigned SOFT_RAMP_US    = 1000;
    localparam int unsigned SOFT_RAMP_CYC   = SOFT_RAMP_US * CLK_MHZ;
    localparam int unsigned DROPOUT_MS      = 37;
    localparam int unsigned DROPOUT_CYC     = DROPOUT_MS * 1000 * CLK_MHZ;
    localparam int unsigned LINE_LOSS_US    = 21300;
    localparam int unsigned LINE_LOSS_CYC   = LINE_LOSS_US * CLK_MHZ;
    localparam int unsigned NTC_LOSS_US     = 100000;
    localparam int unsigned NTC_LOSS_CYC    = NTC_LOSS_US * CLK_MHZ;
    localparam int unsigned SETTLE_US       = 200000;
    localparam int unsigned SETTLE_CYC      = SETTLE_US * CLK_MHZ;
    localparam int unsigned SAFE_ON_NS      = 400;
    localparam int unsigned SAFE_ON_CYC     = SAFE_ON_NS * CLK_MHZ / 1000;
    localparam int unsigned SAFE_OFF_NS     = 2000;
    localparam int unsigned SAFE_OFF_CYC    = SAFE_OFF_NS * CLK_MHZ / 1000;
    localparam int unsigned SHORT_CHECK_CYC = 64;
    localparam int unsigned LOW_LINE_PEAKS  = 3;
    // -------------------------------------------------------------
    // Error voltage and power limits
    // -------------------------------------------------------------
    localparam logic [7:0] VE_MAX  = 8'hff;
    localparam logic [7:0] VE_HALF = 8'h80;
    localparam logic [6:0] PCT_70  = 7'h46;
    localparam logic [6:0] PCT_80  = 7'h50;
    localparam logic [6:0] PCT_90  = 7'h5a;
    localparam logic [6:0] PCT_100 = 7'h64;
    // -------------------------------------------------------------
    // Register port
    // -------------------------------------------------------------
    localparam logic [1:0] REG_CTRL   = 2'h0;
    localparam logic [1:0] REG_STATUS = 2'h1;
    localparam int unsigned CTRL_FOLLOW = 0;
    localparam int unsigned CTRL_ALLOW  = 1;
    localparam logic [7:0] CTRL_RESET = 8'h02;

    typedef enum logic [1:0] {
        PFCPS_PS_LT6K, PFCPS_PS_25K, PFCPS_PS_100K, PFCPS_PS_GT400K
    } pfcps_ps_e;

    // Comparator flags from the analog sense front end
    typedef struct packed {
        logic      bias_upper;
        logic      bias_lower;
        logic      pins_ok;
        logic      line_brown_in_level;
        logic      line_over_max;
        logic      line_brown_out_level;
        logic      thermistor_line_loss_level;
        logic      square_wave_line_loss_level;
        logic      square_wave;
        logic      line_polarity;
        logic      peak_below_low;
        logic      peak_above_high;
        logic      high_line_enter_level;
        logic      gate_on;
        logic      switch_current_limit;
        logic      fb_ov_trip;
        logic      fb_ov_clear;
        logic      fb_short_suspect;
        logic      fb_short_confirm;
        logic      die_hot;
        logic      die_cooled;
        pfcps_ps_e power_limit_select;
    } pfcps_sense_s;

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pfcps_bus_s;
endpackage

// file: hdl/pfcps_sync.sv
`timescale 1ns/100ps
`default_nettype none
module pfcps_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule
`default_nettype wire

// file: hdl/pfcps_supervisor.sv
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Power limit is one of 70, 80, 90, 100 percent from select code.
// - 100k-200k band gives 90 percent, 25k-50k band gives 80 percent.
// - Select code latched at each brown-in, switching enabled afterwards.
// - No switching start below brown-in level or above 400 V line peak.
// - Brown-out only after line stays low longer than debounce.
// - Debounce longer than one lost half-cycle at 47 to 63 Hz.
// - Brown-out waits for zero crossing, then ramps error voltage over 1 ms.
// - After brown-out, restart with pin checks and start-up qualification.
// - After brown-in and settle timer, use thermistor level and debounce.
// - Dip below thermistor level that recovers restarts the settle timer.
// - Staying below thermistor level through its debounce shuts down.
// - Later recovery returns to normal level and debounce.
// - Square-wave line uses the reduced square-wave brown-out level.
// - Start above upper bias lockout, run until below lower lockout.
// - Cut on-time each cycle when switch current reaches the limit.
// - Low-line limit after 3 low peaks, high-line after one high peak.
// - Line drop-out over 37 ms reverts to low-line settings.
// - Follower mode goes high-line at once on high-line level.
// - Short on-time at limit forces safe off-time, lowers error voltage cap by half scale.
// - Suspected feedback short is checked quickly, confirmed short shuts down.
// - Over-temperature soft-shuts down, waits to cool, restarts fully.
// - Power good released as over-temperature shutdown begins.
module pfcps_supervisor
    import pfcps_pkg::*;
#(
    parameter int unsigned SOFT_CYC   = pfcps_pkg::SOFT_RAMP_CYC,
    parameter int unsigned DROP_CYC   = pfcps_pkg::DROPOUT_CYC,
    parameter int unsigned LOSS_CYC   = pfcps_pkg::LINE_LOSS_CYC,
    parameter int unsigned NTC_CYC    = pfcps_pkg::NTC_LOSS_CYC,
    parameter int unsigned SETTLE_CYC = pfcps_pkg::SETTLE_CYC
) (
    input  wire logic                    mclk,
    input  wire logic                    rst_n,
    input  wire pfcps_pkg::pfcps_sense_s sense,
    input  wire logic [7:0]              ve_demand,
    input  wire pfcps_pkg::pfcps_bus_s   bus,
    output logic [7:0]                   rdata,
    output logic                         switch_enable,
    output logic                         soft_ramp_active,
    output logic [7:0]                   internal_error_voltage,
    output logic                         high_line,
    output logic [6:0]                   power_limit,
    output logic                         on_time_cut,
    output logic                         safe_area_mode,
    output logic                         power_good_release
);
    import pfcps_pkg::*;

    // -------------------------------------------------------------
    // Input synchronisation
    // -------------------------------------------------------------
    localparam int unsigned SW = $bits(pfcps_sense_s);
    logic [SW-1:0] sense_q;
    pfcps_sense_s  s;

    pfcps_sync #(.W(SW)) u_sync (
        .mclk  (mclk),
        .rst_n (rst_n),
        .d     (sense),
        .q     (sense_q)
    );
    assign s = pfcps_sense_s'(sense_q);

    function automatic logic [6:0] pct_of(input pfcps_ps_e c);
        unique case (c)
            PFCPS_PS_LT6K:   pct_of = PCT_70;
            PFCPS_PS_25K:    pct_of = PCT_80;
            PFCPS_PS_100K:   pct_of = PCT_90;
            PFCPS_PS_GT400K: pct_of = PCT_100;
        endcase
    endfunction

    // -------------------------------------------------------------
    // Sequencer
    // -------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_LOCKOUT, ST_CHECK, ST_WAIT_IN, ST_LATCH, ST_RUN,
        ST_WAIT_ZC, ST_RAMP, ST_COOL
    } pfcps_state_e;

    pfcps_state_e state;
    pfcps_state_e next_state;
    logic [7:0]   ctrl;
    logic         ntc_mode;
    logic         ot_flag;
    logic         ov_hold;
    logic [31:0]  settle_cnt;
    logic [31:0]  loss_cnt;
    logic [31:0]  drop_cnt;
    logic [31:0]  on_cnt;
    logic [31:0]  off_cnt;
    logic [31:0]  short_cnt;
    logic [31:0]  div_cnt;
    logic [7:0]   ve_cap;
    logic [1:0]   low_peaks;
    logic         pol_d;

    wire zc        = s.line_polarity ^ pol_d;
    wire loss_lvl  = s.square_wave ? s.square_wave_line_loss_level
                                   : s.line_brown_out_level;
    wire below     = ntc_mode ? s.thermistor_line_loss_level : loss_lvl;
    wire [31:0] loss_lim = ntc_mode ? NTC_CYC : LOSS_CYC;
    wire loss_exp  = below && (loss_cnt >= loss_lim);
    wire settle_ex = settle_cnt >= SETTLE_CYC;
    wire short_hit = (short_cnt != 32'h0) && s.fb_short_confirm;
    wire soa_hit   = s.gate_on && s.switch_current_limit
                     && (on_cnt < SAFE_ON_CYC);
    wire tick      = div_cnt >= (SOFT_CYC / 32'(VE_MAX)) - 32'h1;
    wire run_ok    = !ov_hold && ctrl[CTRL_ALLOW] && (off_cnt == 32'h0);
    wire [7:0] cap_dn = (ve_cap > VE_HALF) ? ve_cap - VE_HALF : 8'h00;

    always_comb begin
        next_state = state;
        unique case (state)
            ST_LOCKOUT: if (s.bias_upper) begin
                next_state = ST_CHECK;
            end
            ST_CHECK: if (s.pins_ok && !s.die_hot) begin
                next_state = ST_WAIT_IN;
            end
            ST_WAIT_IN: if (s.line_brown_in_level && !s.line_over_max) begin
                next_state = ST_LATCH;
            end
            ST_LATCH: next_state = ST_RUN;
            ST_RUN: begin
                if (s.die_hot) begin
                    next_state = ST_RAMP;
                end else if (short_hit) begin
                    next_state = ST_RAMP;
                end else if (loss_exp) begin
                    next_state = ST_WAIT_ZC;
                end
            end
            ST_WAIT_ZC: if (zc) begin
                next_state = ST_RAMP;
            end
            ST_RAMP: if (ve_cap == 8'h00) begin
                next_state = ot_flag ? ST_COOL : ST_CHECK;
            end
            ST_COOL: if (s.die_cooled) begin
                next_state = ST_CHECK;
            end
        endcase
        if (!s.bias_lower) begin
            next_state = ST_LOCKOUT;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state   <= ST_LOCKOUT;
            ot_flag <= 1'b0;
        end else begin
            state <= next_state;
            if (state == ST_RUN && s.die_hot) begin
                ot_flag <= 1'b1;
            end else if (state == ST_CHECK) begin
                ot_flag <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------
    // Brown-out timers
    // -------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n || state != ST_RUN) begin
            loss_cnt   <= '0;
            settle_cnt <= '0;
            ntc_mode   <= 1'b0;
        end else begin
            loss_cnt <= below ? loss_cnt + 32'h1 : 32'h0;
            if (!ntc_mode && settle_ex) begin
                ntc_mode   <= 1'b1;
                settle_cnt <= '0;
            end else if (ntc_mode && !below && loss_cnt != 32'h0) begin
                settle_cnt <= '0;
            end else if (ntc_mode && settle_ex && !below) begin
                ntc_mode <= 1'b0;
                loss_cnt <= '0;
            end else if (!settle_ex) begin
                settle_cnt <= settle_cnt + 32'h1;
            end
        end
    end

    // -------------------------------------------------------------
    // Error voltage cap, soft ramp and safe area
    // -------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            div_cnt <= '0;
            ve_cap  <= '0;
            off_cnt <= '0;
            on_cnt  <= '0;
        end else begin
            div_cnt <= tick ? 32'h0 : div_cnt + 32'h1;
            on_cnt  <= s.gate_on ? on_cnt + 32'h1 : 32'h0;
            if (soa_hit && state == ST_RUN) begin
                off_cnt <= SAFE_OFF_CYC;
                ve_cap  <= cap_dn;
            end else begin
                if (off_cnt != 32'h0) begin
                    off_cnt <= off_cnt - 32'h1;
                end
                if (state == ST_RAMP && tick && ve_cap != 8'h00) begin
                    ve_cap <= ve_cap - 8'h01;
                end else if (state == ST_RUN && tick && ve_cap != VE_MAX) begin
                    ve_cap <= ve_cap + 8'h01;
                end else if (state != ST_RUN && state != ST_RAMP
                             && state != ST_WAIT_ZC) begin
                    ve_cap <= '0;
                end
            end
        end
    end

    // -------------------------------------------------------------
    // Overvoltage and feedback short
    // -------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ov_hold   <= 1'b0;
            short_cnt <= '0;
        end else begin
            if (s.fb_ov_trip) begin
                ov_hold <= 1'b1;
            end else if (s.fb_ov_clear) begin
                ov_hold <= 1'b0;
            end
            if (short_cnt != 32'h0) begin
                short_cnt <= short_cnt - 32'h1;
            end else if (s.fb_short_suspect && state == ST_RUN) begin
                short_cnt <= SHORT_CHECK_CYC;
            end
        end
    end

    // -------------------------------------------------------------
    // Line-dependent current limit
    // -------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pol_d     <= 1'b0;
            high_line <= 1'b0;
            low_peaks <= '0;
            drop_cnt  <= '0;
        end else begin
            pol_d    <= s.line_polarity;
            drop_cnt <= zc ? 32'h0 : drop_cnt + 32'h1;
            if (zc) begin
                low_peaks <= s.peak_below_low
                             ? low_peaks + {1'b0, low_peaks != 2'(LOW_LINE_PEAKS)}
                             : 2'h0;
            end
            if (ctrl[CTRL_FOLLOW] && s.high_line_enter_level) begin
                high_line <= 1'b1;
            // one high peak or three low peaks
            end else if (zc && s.peak_above_high) begin
                high_line <= 1'b1;
            end else if (low_peaks == 2'(LOW_LINE_PEAKS)) begin
                high_line <= 1'b0;
            end else if (drop_cnt > DROP_CYC) begin
                high_line <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            switch_enable          <= 1'b0;
            soft_ramp_active       <= 1'b0;
            internal_error_voltage <= '0;
            power_limit            <= PCT_100;
            on_time_cut            <= 1'b0;
            safe_area_mode         <= 1'b0;
            power_good_release     <= 1'b1;
        end else begin
            switch_enable <= (next_state == ST_RUN || next_state == ST_WAIT_ZC
                              || next_state == ST_RAMP) && run_ok;
            soft_ramp_active       <= next_state == ST_RAMP;
            internal_error_voltage <= (ve_demand < ve_cap) ? ve_demand : ve_cap;
            if (state == ST_LATCH) begin
                power_limit <= pct_of(s.power_limit_select);
            end
            on_time_cut    <= s.gate_on && s.switch_current_limit;
            safe_area_mode <= soa_hit || off_cnt > 32'h1;
            power_good_release <= state != ST_RUN || s.die_hot;
        end
    end

    // -------------------------------------------------------------
    // Register port
    // -------------------------------------------------------------
    wire [7:0] status = {state, ntc_mode, ov_hold, ot_flag,
                         high_line, switch_enable};
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctrl  <= CTRL_RESET;
            rdata <= '0;
        end else begin
            if (bus.wr && bus.addr == REG_CTRL) begin
                ctrl <= {6'h00, bus.wdata[1:0]};
            end
            rdata <= !bus.rd ? 8'h00 : (bus.addr == REG_CTRL) ? ctrl
                   : (bus.addr == REG_STATUS) ? status : 8'h00;
        end
    end

    // -------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_bias_lockout_off: assert property (
        !s.bias_lower |=> !switch_enable && state == ST_LOCKOUT)
        else $error("switching survived bias lockout");
    a_run_needs_window: assert property (
        $rose(switch_enable) |-> $past(state == ST_LATCH || state == ST_RUN))
        else $error("switching began before brown-in");
    a_limit_map: assert property (
        state == ST_LATCH |=> power_limit == pct_of($past(s.power_limit_select)))
        else $error("power limit not mapped from select code");
    a_current_cut: assert property (
        s.gate_on && s.switch_current_limit |=> on_time_cut)
        else $error("on-time not cut at current limit");
    a_soa_halve: assert property (
        soa_hit && state == ST_RUN |=> ve_cap == $past(cap_dn)
            && off_cnt == SAFE_OFF_CYC)
        else $error("safe area reaction wrong");
    a_ov_stops: assert property (
        ov_hold |=> !switch_enable)
        else $error("switching during overvoltage hold");
    a_loss_debounce: assert property (
        state == ST_RUN && !below && !s.die_hot && !short_hit && s.bias_lower
            |=> state == ST_RUN)
        else $error("brown-out without debounce");
    a_ve_under_cap: assert property (
        internal_error_voltage <= $past(ve_cap))
        else $error("error voltage above ramp cap");
    a_ot_pg_release: assert property (
        state == ST_RUN && s.die_hot
            |=> power_good_release && state == ST_RAMP)
        else $error("overheat did not release power good");

    c_reach_run:   cover property (state == ST_LATCH ##1 state == ST_RUN);
    c_brownout:    cover property (state == ST_WAIT_ZC ##[1:100] state == ST_RAMP);
    c_high_line:   cover property ($rose(high_line));
    c_safe_area:   cover property (soa_hit && state == ST_RUN);
endmodule
`default_nettype wire

// file: tb/pfcps_sense_model.sv
`timescale 1ns/100ps
`default_nettype none
// Comparator front end: turns a coarse line level code into flags
module pfcps_sense_model #(
    parameter int unsigned HALF = 40
) (
    input  wire logic                 mclk,
    input  wire logic                 bias_on,
    input  wire logic [2:0]           lvl,
    input  wire logic                 hot,
    input  wire logic                 ov,
    input  wire logic                 gate,
    input  wire logic                 cur,
    input  wire logic                 fbs,
    input  wire pfcps_pkg::pfcps_ps_e ps,
    output pfcps_pkg::pfcps_sense_s   sense
);
    import pfcps_pkg::*;
    int unsigned ph  = 0;
    logic        pol = 1'b0;
    // Half-cycle marker stands still while the line is gone
    always_ff @(posedge mclk) begin
        if (lvl == 3'h0) begin
            ph <= 0;
        end else if (ph == HALF - 1) begin
            ph  <= 0;
            pol <= ~pol;
        end else begin
            ph <= ph + 1;
        end
    end
    always_comb begin
        sense = '0;
        sense.bias_upper = bias_on;
        sense.bias_lower = bias_on;
        sense.pins_ok = bias_on;
        sense.line_brown_in_level = (lvl >= 3'h3);
        sense.line_over_max = (lvl == 3'h5);
        sense.line_brown_out_level = (lvl <= 3'h2);
        sense.thermistor_line_loss_level = (lvl <= 3'h1);
        sense.square_wave_line_loss_level = (lvl == 3'h0);
        sense.line_polarity = pol;
        sense.peak_below_low = (lvl <= 3'h3);
        sense.peak_above_high = (lvl >= 3'h4);
        sense.high_line_enter_level = (lvl >= 3'h4);
        sense.gate_on = gate;
        sense.switch_current_limit = cur;
        sense.fb_short_suspect = fbs;
        sense.fb_short_confirm = fbs;
        sense.fb_ov_trip = ov;
        sense.fb_ov_clear = !ov;
        sense.die_hot = hot;
        sense.die_cooled = !hot;
        sense.power_limit_select = ps;
    end
endmodule
`default_nettype wire

// file: tb/tb_pfcps_supervisor.sv
`timescale 1ns/100ps
`default_nettype none
module tb_pfcps_supervisor;
    import pfcps_pkg::*;
    logic         mclk    = 1'b0;
    logic         rst_n   = 1'b0;
    logic         bias_on = 1'b0;
    logic [2:0]   lvl     = 3'h0;
    logic         hot     = 1'b0;
    logic         ov      = 1'b0;
    pfcps_ps_e    ps      = PFCPS_PS_GT400K;
    pfcps_bus_s   bus     = '0;
    pfcps_sense_s sense;
    logic [7:0]   rdata;
    logic [7:0]   ive;
    logic [6:0]   plim;
    logic         sw_en, ramp, hl, pgr, otc, sam;
    logic         gate    = 1'b0;
    logic         cur     = 1'b0;
    logic         fbs     = 1'b0;
    logic [5:0]   flags;
    int           n_errors        = 0;
    int           samples_checked = 0;
    logic [6:0]   pct [4] = '{PCT_70, PCT_80, PCT_90, PCT_100};
    assign flags = {sam, otc, pgr, hl, ramp, sw_en};

    always #2 mclk = ~mclk;

    pfcps_sense_model i_pfcps_sense_model (
        .mclk(mclk), .bias_on(bias_on), .lvl(lvl), .hot(hot), .ov(ov),
        .gate(gate), .cur(cur), .fbs(fbs), .ps(ps), .sense(sense));
    pfcps_supervisor #(.SOFT_CYC(2550), .DROP_CYC(500), .LOSS_CYC(50),
        .NTC_CYC(100), .SETTLE_CYC(200)) i_pfcps_supervisor (
        .mclk(mclk), .rst_n(rst_n), .sense(sense), .ve_demand(8'hc0),
        .bus(bus), .rdata(rdata), .switch_enable(sw_en),
        .soft_ramp_active(ramp), .internal_error_voltage(ive),
        .high_line(hl), .power_limit(plim), .on_time_cut(otc),
        .safe_area_mode(sam), .power_good_release(pgr));

    task give_verdict;
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Waits at falling edges for a flag, bounded, then compares it
    task wait_flag(input int i, input logic v, input int n);
        while (flags[i] !== v && n > 0) begin
            @(negedge mclk);
            n--;
        end
        chk({7'h0, flags[i]}, {7'h0, v});
    endtask
    task knobs(input logic [2:0] l, input logic o, h, b);
        @(posedge mclk);
        lvl     <= l;
        ov      <= o;
        hot     <= h;
        bias_on <= b;
        @(negedge mclk);
    endtask
    task drive(input logic g, c, f);
        @(posedge mclk);
        gate <= g;
        cur  <= c;
        fbs  <= f;
        @(negedge mclk);
    endtask
    task rd_reg(input logic [1:0] a, input logic [7:0] m, e);
        @(posedge mclk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus.rd <= 1'b0;
        #1 chk(rdata & m, e);
    endtask
    task wr_reg(input logic [1:0] a, input logic [7:0] w);
        @(posedge mclk);
        bus <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus.wr <= 1'b0;
    endtask
    // Reset, power up with the line above its maximum, then normal line
    task start(input pfcps_ps_e p);
        @(posedge mclk);
        rst_n <= 1'b0;
        ps    <= p;
        knobs(3'h0, 1'b0, 1'b0, 1'b0);
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        knobs(3'h5, 1'b0, 1'b0, 1'b1);
        repeat (100) @(negedge mclk);
        wait_flag(0, 1'b0, 0);
        knobs(3'h3, 1'b0, 1'b0, 1'b1);
        wait_flag(0, 1'b1, 600);
    endtask

    initial begin
        repeat (40000) @(posedge mclk);
        n_errors++;
        give_verdict;
    end

    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        #1 chk({1'b0, plim}, {1'b0, PCT_100});
        wait_flag(0, 1'b0, 0);
        foreach (pct[k]) begin
            start(pfcps_ps_e'(k));
            chk({1'b0, plim}, {1'b0, pct[k]});
        end
        rd_reg(REG_CTRL, 8'hff, CTRL_RESET);
        rd_reg(REG_STATUS, 8'he1, 8'h81);
        rd_reg(2'h3, 8'hff, 8'h00);
        wr_reg(REG_CTRL, 8'h00);
        wait_flag(0, 1'b0, 8);
        wr_reg(REG_CTRL, CTRL_RESET);
        wait_flag(0, 1'b1, 600);
        knobs(3'h1, 1'b0, 1'b0, 1'b1);
        repeat (20) @(posedge mclk);
        knobs(3'h3, 1'b0, 1'b0, 1'b1);
        wait_flag(1, 1'b0, 0);
        knobs(3'h1, 1'b0, 1'b0, 1'b1);
        wait_flag(1, 1'b1, 300);
        wait_flag(0, 1'b0, 3000);
        knobs(3'h3, 1'b0, 1'b0, 1'b1);
        wait_flag(0, 1'b1, 800);
        knobs(3'h4, 1'b0, 1'b0, 1'b1);
        wait_flag(2, 1'b1, 100);
        knobs(3'h3, 1'b0, 1'b0, 1'b1);
        repeat (45) @(negedge mclk);
        wait_flag(2, 1'b1, 0);
        wait_flag(2, 1'b0, 200);
        wr_reg(REG_CTRL, 8'h03);
        rd_reg(REG_CTRL, 8'hff, 8'h03);
        knobs(3'h4, 1'b0, 1'b0, 1'b1);
        wait_flag(2, 1'b1, 4);
        repeat (45) @(negedge mclk);
        knobs(3'h3, 1'b0, 1'b0, 1'b1);
        wait_flag(2, 1'b0, 200);
        wr_reg(REG_CTRL, CTRL_RESET);
        knobs(3'h3, 1'b1, 1'b0, 1'b1);
        wait_flag(0, 1'b0, 8);
        knobs(3'h3, 1'b0, 1'b0, 1'b1);
        wait_flag(0, 1'b1, 600);
        drive(1'b1, 1'b0, 1'b0);
        repeat (110) @(negedge mclk);
        drive(1'b1, 1'b1, 1'b0);
        wait_flag(4, 1'b1, 8);
        wait_flag(5, 1'b0, 0);
        drive(1'b0, 1'b0, 1'b0);
        drive(1'b1, 1'b1, 1'b0);
        wait_flag(5, 1'b1, 8);
        wait_flag(0, 1'b0, 8);
        repeat (4) @(negedge mclk);
        chk(ive, 8'h00);
        drive(1'b0, 1'b0, 1'b0);
        wait_flag(4, 1'b0, 8);
        wait_flag(0, 1'b1, 600);
        drive(1'b0, 1'b0, 1'b1);
        wait_flag(1, 1'b1, 8);
        drive(1'b0, 1'b0, 1'b0);
        wait_flag(0, 1'b0, 3000);
        wait_flag(0, 1'b1, 800);
        knobs(3'h3, 1'b0, 1'b1, 1'b1);
        wait_flag(3, 1'b1, 8);
        wait_flag(1, 1'b1, 8);
        wait_flag(0, 1'b0, 3000);
        knobs(3'h3, 1'b0, 1'b0, 1'b1);
        wait_flag(0, 1'b1, 800);
        knobs(3'h3, 1'b0, 1'b0, 1'b0);
        wait_flag(0, 1'b0, 8);
        give_verdict;
    end
endmodule
`default_nettype wire
